/* ssrb_bank.sv */
`timescale 1ns/10ps
`include "ssrb_cfg.svh"

module ssrb_bank (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // register access from the serial engine
    input ssrb_pkg::ssrb_req_t req,
    output logic [15:0] rdata,
    output logic rvalid,
    // frame timing
    input wire logic frame_start,
    output logic shadow_loaded,
    // sensor state readbacks
    input ssrb_pkg::ssrb_stat_t stat,
    // live settings
    output ssrb_pkg::ssrb_ctl_t ctl
);

    // ----------------------------------------
    // immediate register table
    // ----------------------------------------
    localparam int NIMM = `SSRB_NIMM;

    localparam logic [7:0] IMM_ADDR [NIMM] = '{
        `SSRB_ADR_EXP_LPF,
        `SSRB_ADR_GAIN_PER,
        `SSRB_ADR_GAIN_LPF,
        `SSRB_ADR_LOOP_EN,
        `SSRB_ADR_PIX_CNT,
        `SSRB_ADR_LNK_MST,
        `SSRB_ADR_LNK_SCK,
        `SSRB_ADR_LNK_DAT,
        `SSRB_ADR_LATENCY,
        `SSRB_ADR_LNK_SYNC,
        `SSRB_ADR_LNK_PAY,
        `SSRB_ADR_STEREO_CTL,
        `SSRB_ADR_MAX_INT,
        `SSRB_ADR_BIN_THR,
        `SSRB_ADR_FLD_BLANK,
        `SSRB_ADR_MON_CAP,
        `SSRB_ADR_ANALOG,
        `SSRB_ADR_TV_SYNC,
        `SSRB_ADR_TV_HBLK,
        `SSRB_ADR_TV_VBLK,
        `SSRB_ADR_BYTE_ADR,
        `SSRB_ADR_LOCK
    };

    localparam logic [15:0] IMM_MASK [NIMM] = '{
        `SSRB_MSK_B0,
        `SSRB_MSK_B3,
        `SSRB_MSK_B1,
        `SSRB_MSK_B1,
        `SSRB_MSK_ALL,
        `SSRB_MSK_B3,
        `SSRB_MSK_LNK,
        `SSRB_MSK_LNK,
        `SSRB_MSK_B1,
        `SSRB_MSK_B0,
        `SSRB_MSK_B0,
        `SSRB_MSK_B2,
        `SSRB_MSK_ALL,
        `SSRB_MSK_B7,
        `SSRB_MSK_B8,
        `SSRB_MSK_B7,
        `SSRB_MSK_ALL,
        `SSRB_MSK_ALL,
        `SSRB_MSK_ALL,
        `SSRB_MSK_ALL,
        `SSRB_MSK_ALL,
        `SSRB_MSK_ALL
    };

    localparam logic [15:0] IMM_RST [NIMM] = '{
        `SSRB_RST_ZERO,
        `SSRB_RST_TWO,
        `SSRB_RST_TWO,
        `SSRB_RST_LOOP_EN,
        `SSRB_RST_PIX_CNT,
        `SSRB_RST_TWO,
        `SSRB_RST_LNK,
        `SSRB_RST_LNK,
        `SSRB_RST_ZERO,
        `SSRB_RST_ZERO,
        `SSRB_RST_ZERO,
        `SSRB_RST_ZERO,
        `SSRB_RST_MAX_INT,
        `SSRB_RST_BIN_THR,
        `SSRB_RST_FLD_BLANK,
        `SSRB_RST_MON_CAP,
        `SSRB_RST_ANALOG,
        `SSRB_RST_TV_SYNC,
        `SSRB_RST_TV_HBLK,
        `SSRB_RST_TV_VBLK,
        `SSRB_RST_ZERO,
        `SSRB_RST_LOCK
    };

    localparam logic [15:0] VERSION_ID = `SSRB_VERSION_ID; // arbitrary value
    localparam int PAD = 16 - `SSRB_COL_W;

    // ----------------------------------------
    // state
    // ----------------------------------------
    ssrb_pkg::ssrb_state_t st;
    ssrb_pkg::ssrb_state_t next_st;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic [15:0] rd_val;
        logic hit;
        rd_val = '0;
        hit = 1'b0;
        next_st = st;
        next_st.rvalid = 1'b0;
        next_st.loaded = 1'b0;

        // frame start: whole window set moves at once
        if (frame_start) begin
            next_st.live.win = st.pend;
            next_st.loaded = 1'b1;
        end

        // host writes
        if (req.wr) begin
            unique case (req.addr)
                `SSRB_ADR_FIRST_COL: begin
                    next_st.pend.first_col =
                        req.wdata[`SSRB_COL_W-1:0];
                end
                `SSRB_ADR_COL_COUNT: begin
                    next_st.pend.col_count =
                        req.wdata[`SSRB_COL_W-1:0];
                end
                default: begin
                    for (int i = 0; i < NIMM; i++) begin
                        if (req.addr == IMM_ADDR[i]) begin
                            next_st.live.imm[i] =
                                req.wdata & IMM_MASK[i];
                        end
                    end
                end
            endcase
        end

        // host reads
        if (req.rd) begin
            unique case (req.addr)
                `SSRB_ADR_VERSION, `SSRB_ADR_VERSION2: begin
                    rd_val = VERSION_ID;
                end
                `SSRB_ADR_FIRST_COL: begin
                    rd_val = {{PAD{1'b0}}, st.pend.first_col};
                end
                `SSRB_ADR_COL_COUNT: begin
                    rd_val = {{PAD{1'b0}}, st.pend.col_count};
                end
                `SSRB_ADR_STEREO_FLG: begin
                    rd_val = {15'h0000, stat.stereo_err};
                end
                `SSRB_ADR_LNK_RDBK: begin
                    rd_val = stat.link_data;
                end
                `SSRB_ADR_GAIN_RDBK: begin
                    rd_val = {9'h000, stat.gain};
                end
                `SSRB_ADR_EXP_RDBK: begin
                    rd_val = stat.exposure;
                end
                `SSRB_ADR_CUR_BIN: begin
                    rd_val = {10'h000, stat.cur_bin};
                end
                `SSRB_ADR_TEMP: begin
                    rd_val = {6'h00, stat.temp};
                end
                default: begin
                    for (int i = 0; i < NIMM; i++) begin
                        if (req.addr == IMM_ADDR[i]) begin
                            rd_val = st.live.imm[i];
                            hit = 1'b1;
                        end
                    end
                    if (!hit) begin
                        rd_val = '0;
                    end
                end
            endcase
            next_st.rdata = rd_val;
            next_st.rvalid = 1'b1;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st.pend.first_col <= `SSRB_RST_FIRST_COL;
            st.pend.col_count <= `SSRB_RST_COL_COUNT;
            st.live.win.first_col <= `SSRB_RST_FIRST_COL;
            st.live.win.col_count <= `SSRB_RST_COL_COUNT;
            for (int i = 0; i < NIMM; i++) begin
                st.live.imm[i] <= IMM_RST[i];
            end
            st.rdata <= '0;
            st.rvalid <= 1'b0;
            st.loaded <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign rdata = st.rdata;
    assign rvalid = st.rvalid;
    assign shadow_loaded = st.loaded;
    assign ctl = st.live;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    logic [`SSRB_COL_W-1:0] wr_col;
    logic wr_first;
    logic rd_first;
    logic wr_loop;
    assign wr_col = req.wdata[`SSRB_COL_W-1:0];
    assign wr_first = req.wr && req.addr == `SSRB_ADR_FIRST_COL;
    assign rd_first = req.rd && req.addr == `SSRB_ADR_FIRST_COL;
    assign wr_loop = req.wr && req.addr == `SSRB_ADR_LOOP_EN;

    a_pend_takes_write:
    assert property (wr_first |=> st.pend.first_col == $past(wr_col))
        else $error("pending first column missed a write");

    a_live_holds_frame:
    assert property (!frame_start |=> $stable(ctl.win))
        else $error("live window changed outside frame start");

    a_live_loads_all:
    assert property (frame_start |=> ctl.win == $past(st.pend))
        else $error("live window not loaded from pending");

    a_load_pulse_time:
    assert property (frame_start |=> shadow_loaded ##1
                     (shadow_loaded == $past(frame_start)))
        else $error("load pulse not tied to frame start");

    a_write_not_live:
    assert property (wr_first && !frame_start ##1 !frame_start |=>
                     ctl.win.first_col == $past(ctl.win.first_col, 2))
        else $error("write reached live copy directly");

    a_read_pending:
    assert property (rd_first |=> rvalid &&
                     rdata == {{PAD{1'b0}}, $past(st.pend.first_col)})
        else $error("read did not return pending first column");

    a_imm_takes_write:
    assert property (wr_loop |=> ctl.imm[3] ==
                     ($past(req.wdata) & `SSRB_MSK_B1))
        else $error("immediate register did not update");

    a_ro_ignores_write:
    assert property (req.wr && req.addr == `SSRB_ADR_VERSION
                     && !frame_start |=> $stable(ctl))
        else $error("write to read-only register changed state");

    a_zero_bits_read:
    assert property (req.rd && req.addr == `SSRB_ADR_LOOP_EN |=>
                     rvalid && rdata[15:2] == 14'h0000)
        else $error("fixed zero bits read nonzero");

    a_rvalid_single:
    assert property (!req.rd |=> !rvalid)
        else $error("read valid without a read");

    // ----------------------------------------
    // further checks
    // ----------------------------------------
    logic wr_count;
    logic rd_count;
    logic wr_rsvd;
    logic rd_flag;
    logic rd_gain;
    logic rd_temp;
    logic rd_version;
    assign wr_count = req.wr && req.addr == `SSRB_ADR_COL_COUNT;
    assign rd_count = req.rd && req.addr == `SSRB_ADR_COL_COUNT;
    assign wr_rsvd = req.wr && req.addr == `SSRB_ADR_RSVD_A7;
    assign rd_flag = req.rd && req.addr == `SSRB_ADR_STEREO_FLG;
    assign rd_gain = req.rd && req.addr == `SSRB_ADR_GAIN_RDBK;
    assign rd_temp = req.rd && req.addr == `SSRB_ADR_TEMP;
    assign rd_version = req.rd && (req.addr == `SSRB_ADR_VERSION
                                   || req.addr == `SSRB_ADR_VERSION2);

    a_count_takes_write:
    assert property (wr_count |=> st.pend.col_count == $past(wr_col))
        else $error("pending column count missed a write");

    a_count_read_pend:
    assert property (rd_count |=> rvalid &&
                     rdata == {{PAD{1'b0}}, $past(st.pend.col_count)})
        else $error("read did not return pending column count");

    a_pend_holds_idle:
    assert property (!wr_first |=> $stable(st.pend.first_col))
        else $error("pending first column changed without a write");

    a_load_needs_frame:
    assert property (shadow_loaded |-> $past(frame_start))
        else $error("load pulse without frame start");

    a_rsvd_ignores_write:
    assert property (wr_rsvd && !frame_start |=> $stable(ctl))
        else $error("write to reserved register changed state");

    a_flag_bits_read:
    assert property (rd_flag |=> rvalid && rdata[15:1] == '0)
        else $error("flag register upper bits read nonzero");

    a_gain_bits_read:
    assert property (rd_gain |=> rvalid && rdata[15:7] == '0)
        else $error("gain readback upper bits read nonzero");

    a_temp_bits_read:
    assert property (rd_temp |=> rvalid && rdata[15:10] == '0)
        else $error("temperature upper bits read nonzero");

    a_version_read:
    assert property (rd_version |=> rvalid && rdata == VERSION_ID)
        else $error("version read returned wrong value");

    a_rvalid_follows:
    assert property (req.rd |=> rvalid)
        else $error("read not answered");

    a_rdata_holds:
    assert property (!req.rd |=> $stable(rdata))
        else $error("read data changed without a read");

    a_imm_holds_idle:
    assert property (!req.wr |=> $stable(ctl.imm))
        else $error("immediate register changed without a write");

    a_lpf_takes_write:
    assert property (req.wr && req.addr == `SSRB_ADR_EXP_LPF |=>
                     ctl.imm[0] == ($past(req.wdata) & `SSRB_MSK_B0))
        else $error("immediate filter register did not update");

    c_write_at_frame: cover property (wr_first && frame_start);
    c_read_after_load: cover property (frame_start ##1 rd_first);
    c_imm_write_read: cover property (wr_loop ##2 req.rd);
    c_count_then_frame: cover property (wr_count ##[1:8] frame_start);
    c_rsvd_write: cover property (wr_rsvd);

endmodule : ssrb_bank

/* ssrb_cfg.svh */
`ifndef SSRB_CFG_SVH
`define SSRB_CFG_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define SSRB_NIMM 22
`define SSRB_ADR_VERSION 8'h00
`define SSRB_ADR_FIRST_COL 8'h01
`define SSRB_ADR_COL_COUNT 8'h04
`define SSRB_ADR_RSVD_A7 8'ha7
`define SSRB_ADR_EXP_LPF 8'ha8
`define SSRB_ADR_GAIN_PER 8'ha9
`define SSRB_ADR_RSVD_AA 8'haa
`define SSRB_ADR_GAIN_LPF 8'hab
`define SSRB_ADR_LOOP_EN 8'haf
`define SSRB_ADR_PIX_CNT 8'hb0
`define SSRB_ADR_LNK_MST 8'hb1
`define SSRB_ADR_LNK_SCK 8'hb2
`define SSRB_ADR_LNK_DAT 8'hb3
`define SSRB_ADR_LATENCY 8'hb4
`define SSRB_ADR_LNK_SYNC 8'hb5
`define SSRB_ADR_LNK_PAY 8'hb6
`define SSRB_ADR_STEREO_CTL 8'hb7
`define SSRB_ADR_STEREO_FLG 8'hb8
`define SSRB_ADR_LNK_RDBK 8'hb9
`define SSRB_ADR_GAIN_RDBK 8'hba
`define SSRB_ADR_EXP_RDBK 8'hbb
`define SSRB_ADR_CUR_BIN 8'hbc
`define SSRB_ADR_MAX_INT 8'hbd
`define SSRB_ADR_BIN_THR 8'hbe
`define SSRB_ADR_FLD_BLANK 8'hbf
`define SSRB_ADR_MON_CAP 8'hc0
`define SSRB_ADR_TEMP 8'hc1
`define SSRB_ADR_ANALOG 8'hc2
`define SSRB_ADR_TV_SYNC 8'hc3
`define SSRB_ADR_TV_HBLK 8'hc4
`define SSRB_ADR_TV_VBLK 8'hc5
`define SSRB_ADR_BYTE_ADR 8'hf0
`define SSRB_ADR_RSVD_F1 8'hf1
`define SSRB_ADR_LOCK 8'hfe
`define SSRB_ADR_VERSION2 8'hff

// ----------------------------------------
// window fields
// ----------------------------------------
`define SSRB_COL_W 10
`define SSRB_RST_FIRST_COL 10'h001
`define SSRB_RST_COL_COUNT 10'h2f0
`define SSRB_VERSION_ID 16'h5a01

// ----------------------------------------
// writable masks
// ----------------------------------------
`define SSRB_MSK_ALL 16'hffff
`define SSRB_MSK_B0 16'h0001
`define SSRB_MSK_B1 16'h0003
`define SSRB_MSK_B2 16'h0007
`define SSRB_MSK_B3 16'h000f
`define SSRB_MSK_LNK 16'h0017
`define SSRB_MSK_B7 16'h00ff
`define SSRB_MSK_B8 16'h01ff

// ----------------------------------------
// reset values
// ----------------------------------------
`define SSRB_RST_ZERO 16'h0000
`define SSRB_RST_TWO 16'h0002
`define SSRB_RST_LOOP_EN 16'h0003
`define SSRB_RST_PIX_CNT 16'habe0
`define SSRB_RST_LNK 16'h0010
`define SSRB_RST_MAX_INT 16'h01e0
`define SSRB_RST_BIN_THR 16'h0014
`define SSRB_RST_FLD_BLANK 16'h0016
`define SSRB_RST_MON_CAP 16'h000a
`define SSRB_RST_ANALOG 16'h0840
`define SSRB_RST_TV_SYNC 16'h3840
`define SSRB_RST_TV_HBLK 16'h4416
`define SSRB_RST_TV_VBLK 16'h4421
`define SSRB_RST_LOCK 16'hbeef

`endif

/* ssrb_host.sv */
`timescale 1ns/10ps

// ----------------------------------------
// serial host model
// ----------------------------------------
module ssrb_host (
    // clock
    input wire logic sys_clk,
    // register access
    output ssrb_pkg::ssrb_req_t req,
    input wire logic [15:0] rdata,
    input wire logic rvalid
);
    initial begin
        req = '0;
    end

    // one write strobe; released fields show inverted junk
    task automatic write_reg(input logic [7:0] addr, input logic [15:0] d);
        @(posedge sys_clk);
        req <= '{1'b1, 1'b0, addr, d};
        @(posedge sys_clk);
        req <= '{1'b0, 1'b0, ~addr, ~d};
    endtask : write_reg

    // one read strobe, answer waited for under a bound
    task automatic read_reg(input logic [7:0] addr, output logic [15:0] d);
        int n;
        @(posedge sys_clk);
        req <= '{1'b0, 1'b1, addr, 16'h0000};
        @(posedge sys_clk);
        req <= '{1'b0, 1'b0, ~addr, 16'hffff};
        n = 0;
        #1;
        while (rvalid !== 1'b1 && n < 8) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        d = (rvalid === 1'b1) ? rdata : 16'hxxxx;
    endtask : read_reg
endmodule : ssrb_host

/* ssrb_pkg.sv */
`include "ssrb_cfg.svh"

package ssrb_pkg;

    typedef struct packed {
        logic [`SSRB_COL_W-1:0] first_col;
        logic [`SSRB_COL_W-1:0] col_count;
    } ssrb_win_t;

    typedef struct packed {
        ssrb_win_t win;
        logic [`SSRB_NIMM-1:0][15:0] imm;
    } ssrb_ctl_t;

    typedef struct packed {
        logic stereo_err;
        logic [15:0] link_data;
        logic [6:0] gain;
        logic [15:0] exposure;
        logic [5:0] cur_bin;
        logic [9:0] temp;
    } ssrb_stat_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } ssrb_req_t;

    typedef struct packed {
        ssrb_win_t pend;
        ssrb_ctl_t live;
        logic [15:0] rdata;
        logic rvalid;
        logic loaded;
    } ssrb_state_t;

endpackage : ssrb_pkg

/* test_sensor_shadow_register_bank.sv */
`timescale 1ns/10ps

module test_sensor_shadow_register_bank;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic sys_clk;
    logic resetn;
    logic frame_start;
    ssrb_pkg::ssrb_req_t req;
    ssrb_pkg::ssrb_stat_t stat;
    ssrb_pkg::ssrb_ctl_t ctl;
    logic [15:0] rdata;
    logic rvalid;
    logic shadow_loaded;
    int failures;
    int compares;
    int cycles;

    ssrb_bank u_ssrb_bank (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .req(req),
        .rdata(rdata),
        .rvalid(rvalid),
        .frame_start(frame_start),
        .shadow_loaded(shadow_loaded),
        .stat(stat),
        .ctl(ctl)
    );

    ssrb_host u_ssrb_host (
        .sys_clk(sys_clk),
        .req(req),
        .rdata(rdata),
        .rvalid(rvalid)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [15:0] e,
                         input logic [15:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : check

    task automatic read_check(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] v;
        u_ssrb_host.read_reg(a, v);
        check($sformatf("reg %h", a), e, v);
    endtask : read_check

    task automatic frame_pulse();
        @(posedge sys_clk);
        frame_start <= 1'b1;
        @(posedge sys_clk);
        frame_start <= 1'b0;
        #1;
    endtask : frame_pulse

    task automatic check_win(input logic [9:0] fc, input logic [9:0] cc);
        check("live first_col", {6'h00, fc}, {6'h00, ctl.win.first_col});
        check("live col_count", {6'h00, cc}, {6'h00, ctl.win.col_count});
    endtask : check_win

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_defaults();
        read_check(8'h00, 16'h5a01);
        read_check(8'hff, 16'h5a01);
        read_check(8'h01, 16'h0001);
        read_check(8'h04, 16'h02f0);
        read_check(8'ha9, 16'h0002);
        read_check(8'hb0, 16'habe0);
        read_check(8'haf, 16'h0003);
        read_check(8'hfe, 16'hbeef);
        check_win(10'h001, 10'h2f0);
        $display("test defaults done");
    endtask : test_defaults

    task automatic test_shadow();
        u_ssrb_host.write_reg(8'h01, 16'hffff);
        u_ssrb_host.write_reg(8'h04, 16'h0100);
        read_check(8'h01, 16'h03ff);
        read_check(8'h04, 16'h0100);
        check_win(10'h001, 10'h2f0);
        frame_pulse();
        check_win(10'h3ff, 10'h100);
        check("loaded", 16'h0001, {15'h0000, shadow_loaded});
        @(posedge sys_clk);
        #1;
        check("loaded", 16'h0000, {15'h0000, shadow_loaded});
        fork
            u_ssrb_host.write_reg(8'h01, 16'h0005);
            frame_pulse();
        join
        check_win(10'h3ff, 10'h100);
        frame_pulse();
        check_win(10'h005, 10'h100);
        $display("test shadow done");
    endtask : test_shadow

    task automatic test_immediate();
        u_ssrb_host.write_reg(8'ha8, 16'hffff);
        #1;
        check("imm a8", 16'h0001, ctl.imm[0]);
        u_ssrb_host.write_reg(8'hb2, 16'hffff);
        read_check(8'hb2, 16'h0017);
        u_ssrb_host.write_reg(8'haf, 16'hfffc);
        read_check(8'haf, 16'h0000);
        u_ssrb_host.write_reg(8'h00, 16'hffff);
        read_check(8'h00, 16'h5a01);
        u_ssrb_host.write_reg(8'hb8, 16'h0000);
        read_check(8'hb8, 16'h0001);
        u_ssrb_host.write_reg(8'ha7, 16'hffff);
        read_check(8'ha7, 16'h0000);
        read_check(8'hc1, 16'h02a5);
        read_check(8'hba, 16'h0055);
        read_check(8'hbb, 16'h1234);
        read_check(8'hb9, 16'hc33c);
        read_check(8'hbc, 16'h002b);
        read_check(8'h10, 16'h0000);
        $display("test immediate done");
    endtask : test_immediate

    task automatic test_reset();
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        check("imm a8", 16'h0000, ctl.imm[0]);
        check_win(10'h001, 10'h2f0);
        @(posedge sys_clk);
        resetn <= 1'b1;
        read_check(8'h01, 16'h0001);
        $display("test reset done");
    endtask : test_reset

    task automatic report_and_stop();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    // ----------------------------------------
    // clock, watchdog and sequence
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            $display("mismatch watchdog expected done seen hang");
            report_and_stop();
        end
    end

    initial begin
        failures = 0;
        compares = 0;
        cycles = 0;
        resetn = 1'b0;
        frame_start = 1'b0;
        stat = '{1'b1, 16'hc33c, 7'h55, 16'h1234, 6'h2b, 10'h2a5};
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        test_defaults();
        test_shadow();
        test_immediate();
        test_reset();
        report_and_stop();
    end
endmodule : test_sensor_shadow_register_bank
